// ==== aq_cfg.svh ====
// Constants for the channel handshake block: offsets, field positions, resets, timing.
`ifndef AQ_CFG_SVH
`define AQ_CFG_SVH

`define AQ_WORD_W 16
`define AQ_CHAR_W 8
`define AQ_DELTA_W 8

`define AQ_OFS_CTRL 6'h00
`define AQ_OFS_STAT 6'h01
`define AQ_OFS_QADR 6'h02
`define AQ_OFS_ACC 6'h03
`define AQ_OFS_PADR 6'h04
`define AQ_OFS_IRQ 6'h05

`define AQ_CTRL_START 0
`define AQ_CTRL_DIR 1
`define AQ_CTRL_DLT_LO 8
`define AQ_CTRL_DLT_HI 15

`define AQ_STAT_BUSY 0
`define AQ_STAT_REPLY 1
`define AQ_STAT_XREJ 2
`define AQ_STAT_IREJ 3
`define AQ_STAT_DONE 4
`define AQ_STAT_CHAR 5

`define AQ_RST_WORD 16'h0000
`define AQ_RST_DELTA 8'h00

`define AQ_CLK_PERIOD_NS 25
`define AQ_RESP_MAX_NS 4000
`define AQ_TMO_FUNC_NS 6000
`define AQ_TMO_IMPL_NS 7000
`define AQ_TMO_CYC ((`AQ_TMO_IMPL_NS + `AQ_CLK_PERIOD_NS - 1) / `AQ_CLK_PERIOD_NS)

`endif

// ==== aq_pkg.sv ====
// Types shared by the channel handshake block.
package aq_pkg;

    typedef enum logic [1:0] {
        AQ_IDLE,
        AQ_WAIT,
        AQ_RESOLVE
    } aq_state_t;

endpackage : aq_pkg

// ==== aq_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none

module aq_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] sync
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync <= '0;
        end
        else
        begin
            meta_q <= pin;
            sync <= meta_q;
        end
    end

endmodule : aq_sync

`default_nettype wire

// ==== aq_timer.sv ====
// Response timeout delay: runs while a request is up, pulses once on expiry.
`timescale 1ns/1ps
`default_nettype none

module aq_timer #(
    parameter int CYC = 280
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    output logic expire
);

    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(CYC - 1);

    logic [CW-1:0] cnt_q;
    logic fired_q;

    // A dropped request restarts the delay, so each request gets the full time.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            fired_q <= 1'b0;
            expire <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= '0;
            fired_q <= 1'b0;
            expire <= 1'b0;
        end
        else
        begin
            expire <= 1'b0;
            if (!fired_q)
            begin
                if (cnt_q == LAST)
                begin
                    fired_q <= 1'b1;
                    expire <= 1'b1;
                end
                else
                begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
        end
    end

    property p_one_pulse;
        @(posedge clk_sys) disable iff (!rst_n) expire |=> !expire;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("timeout pulsed twice");

endmodule : aq_timer

`default_nettype wire

// ==== aq_channel.sv ====
// Processor-side handshake for a programmed single-word parallel I/O channel.
//
// Notes on behaviour
// - input instruction moves one word into accumulator.
// - read line high throughout an input transfer.
// - no answer in six microseconds gives internal reject; the code waits 280 cycles (7000 ns) before it rejects.
// - delay element started by request sets reject.
// - reply continues at instruction address plus one.
// - internal reject branches to address plus offset.
// - external reject branches to address plus one plus offset.
// - write line high for output, same responses.
// - separate read and write request flip-flops.
// - recognised I/O halts the timing sequence.
// - timing resumes on request and response together.
// - request enables drivers, timeout and resume logic.
// - reply and reject set internal flip-flops.
// - character input loads only low accumulator byte.
// - two external interrupt lines ORed together.
// - address from Q, data to or from accumulator.
`timescale 1ns/1ps
`default_nettype none
`include "aq_cfg.svh"

module aq_channel (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    output logic [`AQ_WORD_W-1:0] chan_addr,
    output logic [`AQ_WORD_W-1:0] chan_wdata,
    output logic chan_drv_en,
    output logic chan_read,
    output logic chan_write,
    input wire logic [`AQ_WORD_W-1:0] chan_rdata,
    input wire logic chan_reply,
    input wire logic chan_reject,
    input wire logic chan_char_in,
    input wire logic [1:0] ext_irq,
    output logic irq_req,
    output logic timing_run
);

    localparam int W = `AQ_WORD_W;
    localparam int CH = `AQ_CHAR_W;
    localparam int DW = `AQ_DELTA_W;
    localparam int SW = W + 5;
    localparam int TMO = `AQ_TMO_CYC;
    localparam int TMO_MAX = `AQ_TMO_CYC + 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and response timeout.

    logic [SW-1:0] pins_s;
    logic [W-1:0] rdata_s;
    logic reply_s;
    logic reject_s;
    logic char_s;
    logic [1:0] irq_s;
    logic expire;

    aq_sync #(.W(SW)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin({ext_irq, chan_char_in, chan_reject, chan_reply, chan_rdata}),
        .sync(pins_s)
    );

    assign rdata_s = pins_s[W-1:0];
    assign reply_s = pins_s[W];
    assign reject_s = pins_s[W+1];
    assign char_s = pins_s[W+2];
    assign irq_s = pins_s[W+4:W+3];

    aq_pkg::aq_state_t state_q;
    logic rd_q;
    logic wr_q;
    logic drv_q;
    logic run_q;
    logic rply_q;
    logic xrej_q;
    logic irej_q;
    logic chr_q;
    logic dir_q;
    logic done_q;
    logic irq_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [W-1:0] q_q;
    logic [W-1:0] a_q;
    logic [W-1:0] p_q;
    logic [W-1:0] hold_q;
    logic [DW-1:0] delta_q;

    // The delay element is started by the request line itself.
    aq_timer #(.CYC(TMO)) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(rd_q | wr_q),
        .expire(expire)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, every access acknowledged.

    logic req;
    logic wr_fire;
    logic [5:0] idx;
    logic [W-1:0] wlo;
    logic [31:0] rd_d;
    logic start;
    logic busy;
    logic [W-1:0] dext;
    logic [W-1:0] p_next;
    logic [W-1:0] a_next;
    logic [W-1:0] stat;

    assign req = wb_cyc & wb_stb & !ack_q;
    assign wr_fire = req & wb_we;
    assign idx = wb_adr[7:2];
    assign busy = state_q != aq_pkg::AQ_IDLE;
    assign start = wr_fire && idx == `AQ_OFS_CTRL && wb_sel[0] && wb_dat_w[`AQ_CTRL_START];

    function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [W-1:0] r;
        r = old;
        if (sel[0])
        begin
            r[7:0] = d[7:0];
        end
        if (sel[1])
        begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : merge

    assign wlo = wb_dat_w[W-1:0];
    assign stat = W'({char_s, done_q, irej_q, xrej_q, rply_q, busy});

    always_comb
    begin
        rd_d = 32'h00000000;
        unique case (idx)
            `AQ_OFS_CTRL: rd_d = {16'h0000, delta_q, 6'h00, dir_q, busy};
            `AQ_OFS_STAT: rd_d = {16'h0000, stat};
            `AQ_OFS_QADR: rd_d = {16'h0000, q_q};
            `AQ_OFS_ACC: rd_d = {16'h0000, a_q};
            `AQ_OFS_PADR: rd_d = {16'h0000, p_q};
            `AQ_OFS_IRQ: rd_d = {29'h00000000, irq_s, irq_q};
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= req;
            if (req && !wb_we)
            begin
                rdat_q <= rd_d;
            end
        end
    end

    assign wb_ack = ack_q;
    assign wb_dat_r = rdat_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction setup: address, direction and branch offset.

    // Setup is frozen while a transfer runs so the branch uses the issued offset.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_q <= `AQ_RST_WORD;
            delta_q <= `AQ_RST_DELTA;
            dir_q <= 1'b0;
        end
        else if (!busy && wr_fire)
        begin
            if (idx == `AQ_OFS_QADR)
            begin
                q_q <= merge(q_q, wb_dat_w, wb_sel);
            end
            if (idx == `AQ_OFS_CTRL)
            begin
                if (wb_sel[0])
                begin
                    dir_q <= wb_dat_w[`AQ_CTRL_DIR];
                end
                if (wb_sel[1])
                begin
                    delta_q <= wb_dat_w[`AQ_CTRL_DLT_HI:`AQ_CTRL_DLT_LO];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Handshake sequencer.

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= aq_pkg::AQ_IDLE;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            drv_q <= 1'b0;
            run_q <= 1'b1;
            rply_q <= 1'b0;
            xrej_q <= 1'b0;
            irej_q <= 1'b0;
            chr_q <= 1'b0;
            hold_q <= `AQ_RST_WORD;
        end
        else
        begin
            unique case (state_q)
                aq_pkg::AQ_IDLE:
                begin
                    if (start)
                    begin
                        rd_q <= !wlo[`AQ_CTRL_DIR];
                        wr_q <= wlo[`AQ_CTRL_DIR];
                        drv_q <= 1'b1;
                        run_q <= 1'b0;
                        rply_q <= 1'b0;
                        xrej_q <= 1'b0;
                        irej_q <= 1'b0;
                        chr_q <= 1'b0;
                        state_q <= aq_pkg::AQ_WAIT;
                    end
                end
                aq_pkg::AQ_WAIT:
                begin
                    // Reply wins when both arrive, since the word was moved.
                    if (reply_s)
                    begin
                        rply_q <= 1'b1;
                        hold_q <= rdata_s;
                        chr_q <= char_s & rd_q;
                        state_q <= aq_pkg::AQ_RESOLVE;
                    end
                    else if (reject_s)
                    begin
                        xrej_q <= 1'b1;
                        state_q <= aq_pkg::AQ_RESOLVE;
                    end
                    else if (expire)
                    begin
                        irej_q <= 1'b1;
                        state_q <= aq_pkg::AQ_RESOLVE;
                    end
                end
                aq_pkg::AQ_RESOLVE:
                begin
                    // Resume only here: a request stood and a response was latched.
                    run_q <= (rd_q | wr_q) & (rply_q | xrej_q | irej_q);
                    rd_q <= 1'b0;
                    wr_q <= 1'b0;
                    drv_q <= 1'b0;
                    state_q <= aq_pkg::AQ_IDLE;
                end
                default:
                begin
                    state_q <= aq_pkg::AQ_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Branch target and accumulator update.

    assign dext = {{(W - DW){delta_q[DW-1]}}, delta_q};

    always_comb
    begin
        p_next = p_q;
        a_next = a_q;
        if (rply_q)
        begin
            p_next = p_q + W'(1);
            if (rd_q && chr_q)
            begin
                a_next = {a_q[W-1:CH], hold_q[CH-1:0]};
            end
            else if (rd_q)
            begin
                a_next = hold_q;
            end
        end
        else if (xrej_q)
        begin
            p_next = p_q + W'(1) + dext;
        end
        else if (irej_q)
        begin
            p_next = p_q + dext;
        end
    end

    // Software may preload A and P only while the channel is idle.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_q <= `AQ_RST_WORD;
            p_q <= `AQ_RST_WORD;
        end
        else if (state_q == aq_pkg::AQ_RESOLVE)
        begin
            a_q <= a_next;
            p_q <= p_next;
        end
        else if (!busy && wr_fire)
        begin
            if (idx == `AQ_OFS_ACC)
            begin
                a_q <= merge(a_q, wb_dat_w, wb_sel);
            end
            if (idx == `AQ_OFS_PADR)
            begin
                p_q <= merge(p_q, wb_dat_w, wb_sel);
            end
        end
    end

    // Completion is sticky; a new completion wins over a clear in the same cycle.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_q <= 1'b0;
        end
        else if (state_q == aq_pkg::AQ_RESOLVE)
        begin
            done_q <= 1'b1;
        end
        else if (wr_fire && idx == `AQ_OFS_STAT && wb_sel[0] && wb_dat_w[`AQ_STAT_DONE])
        begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_s[0] | irq_s[1];
        end
    end

    assign chan_addr = q_q;
    assign chan_wdata = a_q;
    assign chan_drv_en = drv_q;
    assign chan_read = rd_q;
    assign chan_write = wr_q;
    assign irq_req = irq_q;
    assign timing_run = run_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_request;
        $rose(rd_q | wr_q);
    endsequence

    sequence s_released;
        !(rd_q | wr_q) && run_q;
    endsequence

    property p_one_dir;
        @(posedge clk_sys) disable iff (!rst_n) !(rd_q && wr_q);
    endproperty
    a_one_dir: assert property (p_one_dir) else $error("read and write both up");

    property p_bounded;
        @(posedge clk_sys) disable iff (!rst_n) s_request |-> ##[1:TMO_MAX] s_released;
    endproperty
    a_bounded: assert property (p_bounded) else $error("request never released");

    property p_halted;
        @(posedge clk_sys) disable iff (!rst_n) (rd_q | wr_q) |-> !run_q;
    endproperty
    a_halted: assert property (p_halted) else $error("timing ran during transfer");

    property p_resume;
        @(posedge clk_sys) disable iff (!rst_n)
            $rose(run_q) |-> $past(rd_q | wr_q) && $past(rply_q | xrej_q | irej_q);
    endproperty
    a_resume: assert property (p_resume) else $error("timing resumed without response");

    property p_reply_pc;
        @(posedge clk_sys) disable iff (!rst_n)
            (state_q == aq_pkg::AQ_RESOLVE && rply_q) |=> p_q == $past(p_q) + W'(1);
    endproperty
    a_reply_pc: assert property (p_reply_pc) else $error("reply target wrong");

    property p_irej_pc;
        @(posedge clk_sys) disable iff (!rst_n)
            (state_q == aq_pkg::AQ_RESOLVE && irej_q) |=> p_q == $past(p_q) + $past(dext);
    endproperty
    a_irej_pc: assert property (p_irej_pc) else $error("internal reject target wrong");

    property p_xrej_pc;
        @(posedge clk_sys) disable iff (!rst_n)
            (state_q == aq_pkg::AQ_RESOLVE && xrej_q)
            |=> p_q == $past(p_q) + W'(1) + $past(dext);
    endproperty
    a_xrej_pc: assert property (p_xrej_pc) else $error("external reject target wrong");

    property p_char_keep;
        @(posedge clk_sys) disable iff (!rst_n)
            (state_q == aq_pkg::AQ_RESOLVE && rply_q && rd_q && chr_q)
            |=> a_q[W-1:CH] == $past(a_q[W-1:CH]) && a_q[CH-1:0] == $past(hold_q[CH-1:0]);
    endproperty
    a_char_keep: assert property (p_char_keep) else $error("character load disturbed A");

    property p_timeout;
        @(posedge clk_sys) disable iff (!rst_n)
            (state_q == aq_pkg::AQ_WAIT && expire && !reply_s && !reject_s) |=> irej_q;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout gave no reject");

    property p_irej_cause;
        @(posedge clk_sys) disable iff (!rst_n)
            $rose(irej_q) |-> $past(expire) && !$past(reply_s) && !$past(reject_s);
    endproperty
    a_irej_cause: assert property (p_irej_cause) else $error("reject without timeout");

    property p_irq_or;
        @(posedge clk_sys) disable iff (!rst_n) ##1 irq_q == ($past(irq_s[0]) | $past(irq_s[1]));
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("interrupt OR wrong");

    property p_cleared;
        @(posedge clk_sys) disable iff (!rst_n)
            state_q == aq_pkg::AQ_RESOLVE |=> !rd_q && !wr_q && !drv_q;
    endproperty
    a_cleared: assert property (p_cleared) else $error("request flops not cleared");

    property p_read_line;
        @(posedge clk_sys) disable iff (!rst_n)
            (start && !busy && !wlo[`AQ_CTRL_DIR]) |=> chan_read && chan_drv_en;
    endproperty
    a_read_line: assert property (p_read_line) else $error("read line not raised");

endmodule : aq_channel

`default_nettype wire

// ==== aq_periph_model.sv ====
// Behavioural peripheral controller on the far side of the channel.
`timescale 1ns/1ps
`default_nettype none
module aq_periph_model #(
    parameter logic [15:0] DEV_ADDR = 16'h0042
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [15:0] chan_addr,
    input wire logic [15:0] chan_wdata,
    input wire logic chan_read,
    input wire logic chan_write,
    input wire logic [1:0] mode,
    input wire logic [7:0] dly,
    input wire logic [15:0] data,
    input wire logic char_en,
    output logic [15:0] chan_rdata,
    output logic chan_reply,
    output logic chan_reject,
    output logic chan_char_in,
    output logic [15:0] wr_seen
);
    logic [7:0] cnt_q;
    logic hit;
    logic now;
    ////////////////////////////////////////
    // Mode 0 replies, mode 1 rejects, mode 2 stays silent to force the timeout.
    assign hit = (chan_read | chan_write) && (chan_addr === DEV_ADDR);
    assign now = hit && (cnt_q == dly) && !chan_reply && !chan_reject;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 8'h00;
            chan_reply <= 1'b0;
            chan_reject <= 1'b0;
            chan_char_in <= 1'b0;
            chan_rdata <= 16'h0000;
            wr_seen <= 16'h0000;
        end
        else if (!(chan_read | chan_write))
        begin
            // Responses drop only once the request has gone.
            cnt_q <= 8'h00;
            chan_reply <= 1'b0;
            chan_reject <= 1'b0;
            chan_char_in <= 1'b0;
            chan_rdata <= ~chan_rdata;
        end
        else
        begin
            if (hit && cnt_q != dly)
                cnt_q <= cnt_q + 8'h01;
            if (now && mode == 2'h0)
            begin
                chan_reply <= 1'b1;
                chan_rdata <= data;
                chan_char_in <= char_en & chan_read;
            end
            else if (!chan_reply)
                chan_rdata <= ~chan_rdata;
            if (now && mode == 2'h1)
                chan_reject <= 1'b1;
            if (now && chan_write)
                wr_seen <= chan_wdata;
        end
    end
endmodule : aq_periph_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the channel handshake block.
`timescale 1ns/1ps
`default_nettype none
`include "aq_cfg.svh"
module testbench;
    localparam logic [15:0] DEV = 16'h0042;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0000_0000;
    logic [31:0] wb_dat_r;
    logic wb_ack, chan_drv_en, chan_read, chan_write, chan_reply, chan_reject;
    logic chan_char_in, irq_req, timing_run;
    logic [15:0] chan_addr, chan_wdata, chan_rdata, wr_seen;
    logic [1:0] ext_irq = 2'h0;
    logic [1:0] p_mode = 2'h0;
    logic [7:0] p_dly = 8'h14;
    logic [15:0] p_data = 16'h0000;
    logic p_char = 1'b0;
    logic req_q = 1'b0;
    int cyc_n = 0, t_rise = 0, t_fall = 0, bad_count = 0, checks_done = 0;
    aq_channel aq_channel_i (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .chan_addr(chan_addr),
        .chan_wdata(chan_wdata), .chan_drv_en(chan_drv_en), .chan_read(chan_read),
        .chan_write(chan_write), .chan_rdata(chan_rdata), .chan_reply(chan_reply),
        .chan_reject(chan_reject), .chan_char_in(chan_char_in), .ext_irq(ext_irq),
        .irq_req(irq_req), .timing_run(timing_run));
    aq_periph_model #(.DEV_ADDR(DEV)) aq_periph_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .chan_addr(chan_addr), .chan_wdata(chan_wdata), .chan_read(chan_read),
        .chan_write(chan_write), .mode(p_mode), .dly(p_dly), .data(p_data), .char_en(p_char),
        .chan_rdata(chan_rdata), .chan_reply(chan_reply), .chan_reject(chan_reject),
        .chan_char_in(chan_char_in), .wr_seen(wr_seen));
    always #12.5 clk_sys = ~clk_sys;
    // Request edges are timed here so the bus polling does not blur the figure.
    always @(posedge clk_sys)
    begin
        cyc_n <= cyc_n + 1;
        if ((chan_read | chan_write) && !req_q)
            t_rise <= cyc_n;
        if (!(chan_read | chan_write) && req_q)
            t_fall <= cyc_n;
        req_q <= chan_read | chan_write;
    end
    ////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask : chk
    task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [15:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'h0};
        wb_sel <= 4'hF;
        wb_dat_w <= {16'h0000, wd};
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            chk("bus answer", 32'h1, 32'h0);
            close_out();
        end
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_xfer
    task automatic wr(input logic [5:0] idx, input logic [15:0] wd);
        logic [31:0] d;
        wb_xfer(1'b1, idx, wd, d);
    endtask : wr
    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        wb_xfer(1'b0, idx, 16'h0000, d);
        chk(nm, exp, d);
    endtask : rd_chk
    ////////////////////////////////////////
    task automatic xfer(input logic dir, input logic [1:0] md, input logic chr,
        input logic [15:0] qa, input logic [7:0] ofs, input logic [15:0] p,
        input logic [15:0] a0, input logic [15:0] din);
        logic irej;
        logic [15:0] ea, ep, sx;
        int n, lo, hi, dur;
        n = 0;
        sx = {{8{ofs[7]}}, ofs};
        irej = (qa !== DEV) || (md == 2'h2);
        ep = irej ? p + sx : (md == 2'h1 ? p + 16'h0001 + sx : p + 16'h0001);
        ea = (dir || md != 2'h0 || irej) ? a0 : (chr ? {a0[15:8], din[7:0]} : din);
        lo = irej ? 280 : p_dly + 2;
        hi = irej ? 286 : p_dly + 8;
        wr(`AQ_OFS_QADR, qa);
        p_mode <= md;
        p_data <= din;
        p_char <= chr;
        wr(`AQ_OFS_ACC, a0);
        wr(`AQ_OFS_PADR, p);
        wr(`AQ_OFS_CTRL, {ofs, 6'h00, dir, 1'b1});
        #1;
        chk("read line", {31'h0, !dir}, chan_read);
        chk("write line", {31'h0, dir}, chan_write);
        chk("driver enable", 32'h1, chan_drv_en);
        chk("timing run busy", 32'h0, timing_run);
        wr(`AQ_OFS_QADR, ~qa);
        #1;
        chk("address", qa, chan_addr);
        while ((chan_read | chan_write) && n < 400)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 400)
        begin
            chk("request drop", 32'h1, 32'h0);
            close_out();
        end
        chk("timing run idle", 32'h1, timing_run);
        chk("driver idle", 32'h0, chan_drv_en);
        rd_chk(`AQ_OFS_ACC, ea, "accumulator");
        rd_chk(`AQ_OFS_PADR, ep, "next address");
        rd_chk(`AQ_OFS_STAT, {26'h0, 2'h1, irej, !irej && md == 2'h1,
            !irej && md == 2'h0, 1'b0}, "status");
        dur = t_fall - t_rise;
        chk("request length", 32'h1, {31'h0, dur >= lo && dur <= hi});
        if (dir)
            chk("written word", a0, wr_seen);
        $display("transfer test done");
    endtask : xfer
    ////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk("timing run reset", 32'h1, timing_run);
        for (int i = 0; i < 8; i++)
            rd_chk(i[5:0], 32'h0, "reset value");
        wr(6'h07, 16'hFFFF);
        rd_chk(6'h07, 32'h0, "unmapped");
        $display("reset test done");
        xfer(1'b0, 2'h0, 1'b0, DEV, 8'h05, 16'h0100, 16'hAAAA, 16'h1357);
        xfer(1'b0, 2'h0, 1'b1, DEV, 8'h05, 16'h0200, 16'h1234, 16'hABCD);
        xfer(1'b0, 2'h1, 1'b0, DEV, 8'hFE, 16'h0300, 16'h4444, 16'h9999);
        xfer(1'b0, 2'h2, 1'b0, DEV, 8'h80, 16'h0010, 16'h5555, 16'h0000);
        xfer(1'b0, 2'h0, 1'b0, 16'h0043, 8'h03, 16'h0400, 16'h6666, 16'h7777);
        xfer(1'b1, 2'h0, 1'b0, DEV, 8'h07, 16'h0500, 16'h5A5A, 16'h0000);
        xfer(1'b1, 2'h1, 1'b0, DEV, 8'h7F, 16'hFFF0, 16'hA5A5, 16'h0000);
        for (int v = 0; v < 4; v++)
        begin
            @(posedge clk_sys);
            ext_irq <= v[1:0];
            repeat (3) @(posedge clk_sys);
            #1;
            chk("interrupt", {31'h0, v != 0}, irq_req);
            rd_chk(`AQ_OFS_IRQ, {29'h0, v[1:0], v != 0}, "interrupt reg");
        end
        $display("interrupt test done");
        wr(`AQ_OFS_STAT, 16'h0010);
        rd_chk(`AQ_OFS_STAT, 32'h4, "done cleared");
        close_out();
    end
endmodule : testbench
`default_nettype wire
